// ===== sim/acm_ain_model.sv
// Analog input source model facing the comparator
module acm_ain_model
(
    // DAC level and input voltage, both in 1/1024 supply steps
    input wire logic [9:0] i_dac_code,
    input wire logic [9:0] i_vin,
    // Comparator result
    output logic o_below
);
    timeunit 1ns;
    timeprecision 1ns;
    assign o_below = i_vin < i_dac_code;
endmodule

// ===== sim/adc_comparator_mode_ctrl_tb.sv
// Testbench for the comparator-mode control
module adc_comparator_mode_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn, set_l, rd_l, beg, skp, mov, mwr, irq, below, done;
    logic [3:0] ra, rb, mdat, isel, oa, ob, mode;
    logic [9:0] scode, sres, dac, vin;
    logic rdv, oskp, flag, busy, sst, rval;
    logic [7:0] lvl;
    logic [8:0] q[$];
    logic [8:0] e;
    int n_errors, n_tests, seed, n;
    acm_ctrl u_dut
    (
        .I_MCLK(clk), .I_RSTN(rstn), .I_REG_A(ra), .I_REG_B(rb),
        .I_SET_LEVEL_INSTR(set_l), .I_READ_LEVEL_INSTR(rd_l),
        .I_BEGIN_COMPARE_INSTR(beg), .I_SKIP_IF_FLAG_INSTR(skp),
        .I_MOVE_LOW_BITS_INSTR(mov), .I_MODE_WR(mwr), .I_MODE_DATA(mdat),
        .I_IRQ_SELECT_REG(isel), .I_IRQ_TAKEN(irq), .I_CMP_BELOW(below),
        .I_SAR_CODE(scode), .I_SAR_RESULT(sres), .I_SAR_DONE(done),
        .O_REG_A(oa), .O_REG_B(ob), .O_RD_VALID(rdv), .O_SKIP(oskp),
        .O_CONVERTER_MODE_REG(mode), .O_COMPARE_FLAG(flag), .O_BUSY(busy),
        .O_SAR_START(sst), .O_RESULT_VALID(rval), .O_DAC_CODE(dac)
    );
    acm_ain_model u_ain
    (
        .i_dac_code(dac),
        .i_vin(vin),
        .o_below(below)
    );
    ////////////////////////////////////////////////////////////////////
    // Clock and checks
    initial
    begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (n_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Read data monitor
    always @(negedge clk)
    begin
        if (rdv !== 1'b0)
        begin
            if (q.size() == 0)
                chk({9'h000, rdv}, 10'h000);
            else
            begin
                e = q.pop_front();
                chk(e[8] ? {2'b00, ob, oa} : {6'h00, oa}, e[8] ? {2'b00, e[7:0]} : {6'h00, e[3:0]});
            end
        end
    end
    initial
    begin
        #3000000;
        n_errors++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////
    // Stimulus
    task automatic strobe(ref logic s);
        s = 1;
        @(negedge clk);
        s = 0;
        @(negedge clk);
    endtask
    task automatic flag_test(input logic use_irq);
        skp = 1;
        @(negedge clk);
        skp = 0;
        chk({8'h00, oskp, flag}, {8'h00, !use_irq, use_irq});
        @(negedge clk);
        if (use_irq)
        begin
            strobe(irq);
            chk({9'h000, flag}, 10'h000);
        end
    endtask
    task automatic compare(input logic use_irq);
        isel = {1'b0, use_irq, 2'b00};
        beg = 1;
        @(negedge clk);
        beg = 0;
        chk({8'h00, sst, busy}, 10'h001);
        n = 0;
        while (busy === 1'b1 && n < 40)
        begin
            n++;
            @(negedge clk);
        end
        chk({9'h000, n >= 22 && n <= 24}, 10'h001);
        @(negedge clk);
        chk({9'h000, flag}, {9'h000, vin < {lvl, 2'b00}});
        if (flag === 1'b1)
            flag_test(use_irq);
    endtask
    initial
    begin
        {rstn, set_l, rd_l, beg, skp, mov, mwr, irq, done, ra, rb, mdat, isel, vin} = '0;
        n_errors = 0;
        n_tests = 0;
        seed = 32'h4096;
        scode = 10'($random(seed));
        sres = 10'($random(seed));
        repeat (5) @(negedge clk);
        rstn = 1;
        chk({mode, flag, busy, rval, 3'h0}, 10'h000);
        strobe(done);
        chk({8'h00, rval, flag}, 10'h003);
        flag_test(1'b0);
        beg = 1;
        @(negedge clk);
        beg = 0;
        chk({7'h00, sst, busy, flag}, 10'h004);
        chk(dac, scode);
        @(negedge clk);
        chk({9'h000, sst}, 10'h000);
        q.push_back({1'b0, 4'h0, sres[1:0], 2'b00});
        strobe(mov);
        strobe(rd_l);
        mdat = 4'h8;
        strobe(mwr);
        chk({5'h00, mode, rval}, 10'h010);
        for (int i = 0; i < 4; i++)
        begin
            ra = 4'($random(seed));
            rb = 4'($random(seed));
            lvl = {rb, ra};
            strobe(set_l);
            q.push_back({1'b1, lvl});
            strobe(rd_l);
            chk(dac, {lvl, 2'b00});
            vin = (i < 2) ? {lvl, 2'b00} - 10'h001 : {lvl, 2'b00};
            compare(i[0]);
        end
        isel = 4'h0;
        mdat = 4'h0;
        strobe(mwr);
        chk({8'h00, flag, mode[3]}, 10'h002);
        flag_test(1'b0);
        mdat = 4'h8;
        strobe(mwr);
        q.push_back({1'b1, lvl});
        strobe(rd_l);
        repeat (2) @(negedge clk);
        chk(10'(q.size()), 10'h000);
        conclude();
    end
endmodule

// ===== src/acm_ctrl.sv
// Comparator-mode control of the on-chip A/D converter
//
// How it works
// - Level-set instruction loads B into upper nibble, A into lower nibble.
// - Entering comparator mode marks the conversion result as undefined.
// - Level register is separate and keeps its value in conversion mode.
// - Level register is written and read only in comparator mode.
// - In comparator mode the DAC code is the level, step VDD/256.
// - Compare flag holds the outcome: set when input is below level.
// - Flag clears on interrupt taken or on skip, chosen by interrupt select.
// - Start begins a compare ending 8 machine cycles later, then flags.
// - Low-bits move puts result bits 1:0 into A[3:2], A[1:0] zero.
// - Leaving comparator mode sets the flag; with skip selected, software skips to clear it.
// - Mode bit 3 high selects comparator mode, low selects conversion.
`include "acm_map.svh"

module acm_ctrl
(
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RSTN,
    // CPU registers A and B
    input wire logic [3:0] I_REG_A,
    input wire logic [3:0] I_REG_B,
    // Instruction strobes
    input wire logic I_SET_LEVEL_INSTR,
    input wire logic I_READ_LEVEL_INSTR,
    input wire logic I_BEGIN_COMPARE_INSTR,
    input wire logic I_SKIP_IF_FLAG_INSTR,
    input wire logic I_MOVE_LOW_BITS_INSTR,
    input wire logic I_MODE_WR,
    input wire logic [3:0] I_MODE_DATA,
    // Interrupt control
    input wire logic [3:0] I_IRQ_SELECT_REG,
    input wire logic I_IRQ_TAKEN,
    // Analog comparator and conversion sequencer
    input wire logic I_CMP_BELOW,
    input wire logic [9:0] I_SAR_CODE,
    input wire logic [9:0] I_SAR_RESULT,
    input wire logic I_SAR_DONE,
    // Data back to the CPU
    output logic [3:0] O_REG_A,
    output logic [3:0] O_REG_B,
    output logic O_RD_VALID,
    output logic O_SKIP,
    // Converter state
    output logic [3:0] O_CONVERTER_MODE_REG,
    output logic O_COMPARE_FLAG,
    output logic O_BUSY,
    output logic O_SAR_START,
    output logic O_RESULT_VALID,
    output logic [9:0] O_DAC_CODE
);

    ////////////////////////////////////////////////////////////////////////////
    // Machine-cycle enable

    logic tick;

    acm_tick u_tick
    (
        .i_clk (I_MCLK),
        .i_rstn (I_RSTN),
        .o_tick (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    acm_pkg::acm_state_t state_r;
    logic [2:0] mcyc_r;
    logic [7:0] level_r;
    logic [9:0] result_r;
    logic mode_cmp;
    logic irq_mode;
    logic start_cmp;
    logic cmp_end;
    logic to_conv;
    logic to_cmp;
    logic flag_set;
    logic flag_clr;
    logic flag_nxt;

    assign mode_cmp = O_CONVERTER_MODE_REG[`ACM_MODE_BIT];
    assign irq_mode = I_IRQ_SELECT_REG[`ACM_IRQSEL_BIT];
    assign start_cmp = I_BEGIN_COMPARE_INSTR && mode_cmp && (state_r == acm_pkg::ACM_IDLE);
    assign cmp_end = (state_r == acm_pkg::ACM_RUN) && tick && (mcyc_r == `ACM_CMP_LAST);
    assign to_conv = I_MODE_WR && mode_cmp && !I_MODE_DATA[`ACM_MODE_BIT];
    assign to_cmp = I_MODE_WR && !mode_cmp && I_MODE_DATA[`ACM_MODE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Mode register

    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            O_CONVERTER_MODE_REG <= `ACM_MODE_RST;
        else if (I_MODE_WR)
            O_CONVERTER_MODE_REG <= I_MODE_DATA;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Comparison level register

    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            level_r <= `ACM_LEVEL_RST;
        else if (I_SET_LEVEL_INSTR && mode_cmp)
            level_r <= {I_REG_B, I_REG_A};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare sequencer

    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            state_r <= acm_pkg::ACM_IDLE;
            mcyc_r <= 3'h0;
        end
        else
        begin
            case (state_r)
                acm_pkg::ACM_IDLE:
                begin
                    mcyc_r <= 3'h0;
                    if (start_cmp)
                        state_r <= acm_pkg::ACM_RUN;
                end
                acm_pkg::ACM_RUN:
                begin
                    if (cmp_end)
                        state_r <= acm_pkg::ACM_IDLE;
                    else if (tick)
                        mcyc_r <= mcyc_r + 3'h1;
                end
                default:
                begin
                    state_r <= acm_pkg::ACM_IDLE;
                    mcyc_r <= 3'h0;
                end
            endcase
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            O_BUSY <= 1'b0;
        else if (start_cmp)
            O_BUSY <= 1'b1;
        else if (cmp_end)
            O_BUSY <= 1'b0;
    end

    // Start in conversion mode goes to the sequencer
    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            O_SAR_START <= 1'b0;
        else
            O_SAR_START <= I_BEGIN_COMPARE_INSTR && !mode_cmp;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare flag

    assign flag_set = (cmp_end && I_CMP_BELOW)
        || (I_SAR_DONE && !mode_cmp)
        || to_conv;
    assign flag_clr = (irq_mode && I_IRQ_TAKEN)
        || (!irq_mode && I_SKIP_IF_FLAG_INSTR && O_COMPARE_FLAG);

    always_comb
    begin
        flag_nxt = O_COMPARE_FLAG;
        if (flag_set)
            flag_nxt = 1'b1;
        else if (flag_clr)
            flag_nxt = 1'b0;
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            O_COMPARE_FLAG <= 1'b0;
        else
            O_COMPARE_FLAG <= flag_nxt;
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            O_SKIP <= 1'b0;
        else
            O_SKIP <= I_SKIP_IF_FLAG_INSTR && O_COMPARE_FLAG && !irq_mode;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion result

    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            result_r <= `ACM_RESULT_RST;
            O_RESULT_VALID <= 1'b0;
        end
        else if (to_cmp)
            O_RESULT_VALID <= 1'b0;
        else if (I_SAR_DONE && !mode_cmp)
        begin
            result_r <= I_SAR_RESULT;
            O_RESULT_VALID <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // DAC drive

    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            O_DAC_CODE <= 10'h000;
        else if (mode_cmp)
            O_DAC_CODE <= {level_r, 2'b00};
        else
            O_DAC_CODE <= I_SAR_CODE;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reads back to A and B

    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            O_REG_A <= 4'h0;
            O_REG_B <= 4'h0;
            O_RD_VALID <= 1'b0;
        end
        else if (I_READ_LEVEL_INSTR && mode_cmp)
        begin
            O_REG_A <= level_r[3:0];
            O_REG_B <= level_r[7:4];
            O_RD_VALID <= 1'b1;
        end
        else if (I_MOVE_LOW_BITS_INSTR)
        begin
            O_REG_A <= {result_r[1:0], 2'b00};
            O_RD_VALID <= 1'b1;
        end
        else
            O_RD_VALID <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_start;
        start_cmp;
    endsequence

    sequence s_run;
        O_BUSY [*8] ##1 O_BUSY [*8] ##1 O_BUSY [*6] ##[1:3] !O_BUSY;
    endsequence

    a_level_write: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        I_SET_LEVEL_INSTR && mode_cmp |=> level_r == {$past(I_REG_B), $past(I_REG_A)})
        else $error("level load wrong");

    a_level_locked: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        !mode_cmp |=> $stable(level_r))
        else $error("level changed outside comparator mode");

    a_read_refused: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        I_READ_LEVEL_INSTR && !mode_cmp && !I_MOVE_LOW_BITS_INSTR |=> !O_RD_VALID)
        else $error("level read outside comparator mode");

    a_dac_level: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        mode_cmp |=> O_DAC_CODE == {$past(level_r), 2'b00})
        else $error("dac not at level");

    a_compare_span: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        s_start |=> s_run)
        else $error("compare length wrong");

    a_compare_ticks: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        $fell(O_BUSY) |-> $past(mcyc_r) == `ACM_CMP_LAST)
        else $error("compare ended early");

    a_flag_below: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        cmp_end && I_CMP_BELOW |=> O_COMPARE_FLAG)
        else $error("flag not set on below");

    a_flag_above: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        cmp_end && !I_CMP_BELOW && !O_COMPARE_FLAG && !to_conv |=> !O_COMPARE_FLAG)
        else $error("flag set on above");

    a_skip_clear: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        I_SKIP_IF_FLAG_INSTR && O_COMPARE_FLAG && !irq_mode && !flag_set |=> !O_COMPARE_FLAG && O_SKIP)
        else $error("skip did not clear flag");

    a_irq_clear: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        irq_mode && I_IRQ_TAKEN && !flag_set |=> !O_COMPARE_FLAG && !O_SKIP)
        else $error("interrupt did not clear flag");

    a_low_bits: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        I_MOVE_LOW_BITS_INSTR && !(I_READ_LEVEL_INSTR && mode_cmp)
        |=> O_REG_A == {$past(result_r[1:0]), 2'b00})
        else $error("low bits move wrong");

    a_result_undef: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        to_cmp |=> !O_RESULT_VALID)
        else $error("result still valid in comparator mode");

    a_mode_flag: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        to_conv |=> O_COMPARE_FLAG ##1 (O_COMPARE_FLAG || $past(flag_clr)))
        else $error("flag not raised on leaving comparator mode");

    a_mode_select: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        I_MODE_WR |=> mode_cmp == $past(I_MODE_DATA[`ACM_MODE_BIT]))
        else $error("mode bit not taken");

endmodule

// ===== src/acm_map.svh
// Field positions, reset values and timing counts for the comparator-mode control
`ifndef ACM_MAP_SVH
`define ACM_MAP_SVH

// Converter mode register: bit 3 selects comparator mode
`define ACM_MODE_BIT 3
`define ACM_MODE_RST 4'h0

// Interrupt select register: bit 2 selects interrupt over skip
`define ACM_IRQSEL_BIT 2

// Comparison level register
`define ACM_LEVEL_RST 8'h00

// Result register reset value
`define ACM_RESULT_RST 10'h000

// Machine cycles of one comparison
`define ACM_CMP_MCYC 8
`define ACM_CMP_LAST 3'h7

// Master clocks per machine cycle
`define ACM_MCYC_DIV 3
`define ACM_DIV_LAST 2'h2

`endif

// ===== src/acm_pkg.sv
// Types shared by the comparator-mode control
package acm_pkg;

    typedef enum logic [1:0]
    {
        ACM_IDLE = 2'b00,
        ACM_RUN = 2'b01
    } acm_state_t;

endpackage

// ===== src/acm_tick.sv
// Machine-cycle enable divider
`include "acm_map.svh"

module acm_tick
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Enable pulse
    output logic o_tick
);

    logic [1:0] cnt_r;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cnt_r <= 2'h0;
            o_tick <= 1'b0;
        end
        else if (cnt_r == `ACM_DIV_LAST)
        begin
            cnt_r <= 2'h0;
            o_tick <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 2'h1;
            o_tick <= 1'b0;
        end
    end

endmodule
